// ---- rtl/eelc_edge_catch.sv ----
// Pulse catcher that turns edges of arbitrarily narrow line pulses into clock-domain pulses.
`timescale 1ns/10ps

module eelc_edge_catch #(
   parameter int W = 19
) (
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic [W-1:0] line_i,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);

   // Refuse an empty line set at elaboration.
   if (W < 1) begin : g_bad_width
      $error("eelc_edge_catch needs at least one line");
   end

   for (genvar g = 0; g < W; g++) begin : g_line
      logic       rise_tgl_reg;
      logic       fall_tgl_reg;
      logic [2:0] rise_sync_reg;
      logic [2:0] fall_sync_reg;

      // The line edge itself clocks a toggle, so a pulse shorter than a clock period still flips it.
      always_ff @(posedge line_i[g] or negedge arst_n_i) begin
         if (!arst_n_i) begin
            rise_tgl_reg <= 1'b0;
         end else begin
            rise_tgl_reg <= ~rise_tgl_reg; // RQ5
         end
      end

      // Falling edges flip their own toggle.
      always_ff @(negedge line_i[g] or negedge arst_n_i) begin
         if (!arst_n_i) begin
            fall_tgl_reg <= 1'b0;
         end else begin
            fall_tgl_reg <= ~fall_tgl_reg; // RQ5
         end
      end

      // Toggles cross into the clock domain; stage 0 feeds only stage 1.
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            rise_sync_reg <= 3'h0;
            fall_sync_reg <= 3'h0;
            rise_o[g]     <= 1'b0;
            fall_o[g]     <= 1'b0;
         end else begin
            rise_sync_reg <= {rise_sync_reg[1:0], rise_tgl_reg};
            fall_sync_reg <= {fall_sync_reg[1:0], fall_tgl_reg};
            rise_o[g]     <= rise_sync_reg[2] ^ rise_sync_reg[1]; // RQ5
            fall_o[g]     <= fall_sync_reg[2] ^ fall_sync_reg[1]; // RQ5
         end
      end
   end

endmodule // eelc_edge_catch

// ---- rtl/eelc_map.svh ----
// Register offsets, field positions, reset values and widths of the edge event line controller.
`ifndef EELC_MAP_SVH
`define EELC_MAP_SVH

`define EELC_NUM_LINES     19
`define EELC_NUM_EXT       16
`define EELC_SEL_W         6
`define EELC_ADDR_W        8
`define EELC_LINE_SUPPLY   16
`define EELC_LINE_ALARM    17
`define EELC_LINE_SPARE    18

`define EELC_OFF_INT_EN    8'h00
`define EELC_OFF_EVT_EN    8'h04
`define EELC_OFF_RISE_EN   8'h08
`define EELC_OFF_FALL_EN   8'h0C
`define EELC_OFF_PEND      8'h10
`define EELC_OFF_SEL_BASE  8'h20

`define EELC_RST_MASK      19'h00000
`define EELC_RST_SEL       6'h00

`endif

// ---- rtl/eelc_pkg.sv ----
// Types of the edge event line controller.
`include "eelc_map.svh"

package eelc_pkg;

   typedef logic [`EELC_NUM_LINES-1:0] eelc_lines_t;
   typedef logic [`EELC_SEL_W-1:0]     eelc_sel_t;

   // Register bus request as seen by the controller.
   typedef struct packed {
      logic [`EELC_ADDR_W-1:0] addr;
      logic [31:0]             wdata;
      logic                    wr;
      logic                    rd;
   } eelc_bus_t;

   // Clocked state of the controller top, apart from the edge catcher's own registers.
   typedef struct packed {
      eelc_lines_t                          int_en;
      eelc_lines_t                          evt_en;
      eelc_lines_t                          rise_en;
      eelc_lines_t                          fall_en;
      eelc_lines_t                          pend;
      eelc_sel_t [`EELC_NUM_EXT-1:0]        sel;
      logic [31:0]                          rdata;
      eelc_lines_t                          irq_lines;
      logic                                 irq;
      eelc_lines_t                          evt;
      logic                                 wake;
   } eelc_state_t;

endpackage

// ---- rtl/eelc_top.sv ----
// Edge event line controller: line routing, trigger select, masks, pending status and requests.
//
// Contract
// RQ1 - There are 19 independent edge lines, each able to raise an interrupt and an event request.
// RQ2 - Each line separately triggers on rising edges, falling edges or both, as software selects.
// RQ3 - Each line has its own masks, so a masked line makes no request and others are unaffected.
// RQ4 - A pending bit per line records a detected trigger and software reads it as request status; the code sets it only on lines enabled in int_en.
// RQ5 - Input pulses narrower than one bus clock period are still caught by the edge detection.
// RQ6 - Up to 51 general pins are routed onto 16 external lines, each fed by a selected pin.
// RQ7 - The remaining lines are fed by the supply threshold detector and the calendar alarm; the code feeds line 18 from spare_src_i instead.
// RQ8 - An unmasked trigger on any line can wake the device from its clock-stopped state; the code registers wake_o on clk_i, so clk_i must run.
// RQ9 - A pending bit stays set until software clears it, and a new trigger keeps it set.
`timescale 1ns/10ps
`include "eelc_map.svh"

module eelc_top
   import eelc_pkg::*;
#(
   parameter int NUM_PINS = 51
) (
   input  wire logic                    clk_i,
   input  wire logic                    arst_n_i,
   input  wire logic [NUM_PINS-1:0]     pins_i,
   input  wire logic                    supply_threshold_detector_i,
   input  wire logic                    calendar_alarm_i,
   input  wire logic                    spare_src_i,
   input  wire logic [`EELC_ADDR_W-1:0] addr_i,
   input  wire logic [31:0]             wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic      [31:0]             rdata_o,
   output logic      [`EELC_NUM_LINES-1:0] irq_lines_o,
   output logic                         irq_o,
   output logic      [`EELC_NUM_LINES-1:0] evt_o,
   output logic                         wake_o
);

   // Pin selectors must be able to address every pin, so the pin count is refused beyond their reach.
   if (NUM_PINS < 1 || NUM_PINS > (1 << `EELC_SEL_W)) begin : g_bad_pins
      $error("eelc_top: NUM_PINS out of range");
   end

   eelc_state_t state_reg;
   eelc_state_t state_next;
   eelc_bus_t   bus;
   eelc_lines_t line_src;
   eelc_lines_t rise_det;
   eelc_lines_t fall_det;
   eelc_lines_t trig;

   // Returns true when the request hits the given word offset.
   function automatic logic hit(input logic [`EELC_ADDR_W-1:0] a,
                                input logic [`EELC_ADDR_W-1:0] off);
      return a == off;
   endfunction

   // Returns the index of the pin selector addressed, or a value past the last when none is.
   function automatic logic [4:0] sel_index(input logic [`EELC_ADDR_W-1:0] a);
      logic [`EELC_ADDR_W-1:0] rel;
      rel = a - `EELC_OFF_SEL_BASE;
      if (a >= `EELC_OFF_SEL_BASE && rel[1:0] == 2'h0 && rel[`EELC_ADDR_W-1:2] < `EELC_NUM_EXT) begin
         return rel[6:2];
      end
      return 5'h1F;
   endfunction

   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // External lines take the selected pin; out-of-range selections give a quiet low line.
   // Changing a selector can itself look like an edge, so mask the line while reprogramming it.
   always_comb begin
      for (int i = 0; i < `EELC_NUM_EXT; i++) begin
         if (int'(state_reg.sel[i]) < NUM_PINS) begin
            line_src[i] = pins_i[state_reg.sel[i]]; // RQ6
         end else begin
            line_src[i] = 1'b0;
         end
      end
      line_src[`EELC_LINE_SUPPLY] = supply_threshold_detector_i; // RQ7
      line_src[`EELC_LINE_ALARM]  = calendar_alarm_i; // RQ7
      line_src[`EELC_LINE_SPARE]  = spare_src_i;
   end

   eelc_edge_catch #(
      .W (`EELC_NUM_LINES)
   ) u_catch (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .line_i   (line_src),
      .rise_o   (rise_det),
      .fall_o   (fall_det)
   );

   // A line triggers on each edge kind that software has enabled for it.
   assign trig = (rise_det & state_reg.rise_en) | (fall_det & state_reg.fall_en); // RQ2

   // Next-state logic: register writes, pending bits, requests and read data.
   always_comb begin
      logic [4:0]  si;
      eelc_lines_t clr;
      state_next = state_reg;
      si         = sel_index(bus.addr);
      clr        = '0;
      if (bus.wr) begin
         if (hit(bus.addr, `EELC_OFF_INT_EN)) begin
            state_next.int_en = bus.wdata[`EELC_NUM_LINES-1:0];
         end
         if (hit(bus.addr, `EELC_OFF_EVT_EN)) begin
            state_next.evt_en = bus.wdata[`EELC_NUM_LINES-1:0];
         end
         if (hit(bus.addr, `EELC_OFF_RISE_EN)) begin
            state_next.rise_en = bus.wdata[`EELC_NUM_LINES-1:0];
         end
         if (hit(bus.addr, `EELC_OFF_FALL_EN)) begin
            state_next.fall_en = bus.wdata[`EELC_NUM_LINES-1:0];
         end
         if (hit(bus.addr, `EELC_OFF_PEND)) begin
            clr = bus.wdata[`EELC_NUM_LINES-1:0];
         end
         if (si < 5'(`EELC_NUM_EXT)) begin
            state_next.sel[si[3:0]] = bus.wdata[`EELC_SEL_W-1:0];
         end
      end
      // A new trigger wins over a clear in the same cycle.
      state_next.pend      = (state_reg.pend & ~clr) | (trig & state_reg.int_en); // RQ9 RQ3 RQ4
      state_next.irq_lines = state_next.pend & state_reg.int_en; // RQ1 RQ3
      state_next.irq       = |(state_next.pend & state_reg.int_en);
      state_next.evt       = trig & state_reg.evt_en; // RQ1 RQ3
      state_next.wake      = |(trig & (state_reg.int_en | state_reg.evt_en)) |
                             |(state_next.pend & state_reg.int_en); // RQ8
      // Read data stands for exactly the cycle after the read strobe.
      state_next.rdata = 32'h0000_0000;
      if (bus.rd) begin
         if (hit(bus.addr, `EELC_OFF_INT_EN)) begin
            state_next.rdata[`EELC_NUM_LINES-1:0] = state_reg.int_en;
         end
         if (hit(bus.addr, `EELC_OFF_EVT_EN)) begin
            state_next.rdata[`EELC_NUM_LINES-1:0] = state_reg.evt_en;
         end
         if (hit(bus.addr, `EELC_OFF_RISE_EN)) begin
            state_next.rdata[`EELC_NUM_LINES-1:0] = state_reg.rise_en;
         end
         if (hit(bus.addr, `EELC_OFF_FALL_EN)) begin
            state_next.rdata[`EELC_NUM_LINES-1:0] = state_reg.fall_en;
         end
         if (hit(bus.addr, `EELC_OFF_PEND)) begin
            state_next.rdata[`EELC_NUM_LINES-1:0] = state_reg.pend; // RQ4
         end
         if (si < 5'(`EELC_NUM_EXT)) begin
            state_next.rdata[`EELC_SEL_W-1:0] = state_reg.sel[si[3:0]];
         end
      end
   end

   // State register; everything clears on reset.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg         <= '0;
         state_reg.int_en  <= `EELC_RST_MASK;
         state_reg.evt_en  <= `EELC_RST_MASK;
         state_reg.rise_en <= `EELC_RST_MASK;
         state_reg.fall_en <= `EELC_RST_MASK;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_o     = state_reg.rdata;
   assign irq_lines_o = state_reg.irq_lines;
   assign irq_o       = state_reg.irq;
   assign evt_o       = state_reg.evt;
   assign wake_o      = state_reg.wake;

endmodule // eelc_top

// ---- sim/eelc_props.sv ----
// Concurrent checks on the ports of the edge event line controller.
`timescale 1ns/10ps
`include "eelc_map.svh"
module eelc_props #(
   parameter int NUM_PINS = 51
) (
   input wire logic                        clk_i,
   input wire logic                        arst_n_i,
   input wire logic [NUM_PINS-1:0]         pins_i,
   input wire logic                        supply_threshold_detector_i,
   input wire logic                        calendar_alarm_i,
   input wire logic                        spare_src_i,
   input wire logic [`EELC_ADDR_W-1:0]     addr_i,
   input wire logic [31:0]                 wdata_i,
   input wire logic                        wr_i,
   input wire logic                        rd_i,
   input wire logic [31:0]                 rdata_o,
   input wire logic [`EELC_NUM_LINES-1:0]  irq_lines_o,
   input wire logic                        irq_o,
   input wire logic [`EELC_NUM_LINES-1:0]  evt_o,
   input wire logic                        wake_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Bus read data and its width limits.
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   a_line_width: assert property ($past(rd_i) && $past(addr_i) < 8'h20 |-> rdata_o[31:19] == 13'h0)
      else $error("line register bits above 18 set");
   a_sel_width: assert property ($past(rd_i) && $past(addr_i) >= 8'h20 |-> rdata_o[31:6] == 26'h0)
      else $error("selector bits above 5 set");
   a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h14 |-> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   // Request outputs agree with each other and with the writes that clear them.
   a_irq_any: assert property (irq_o == |irq_lines_o)
      else $error("irq differs from line requests");
   a_wake_irq: assert property (irq_o |-> wake_o)
      else $error("no wake during interrupt");
   a_irq_sticky: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
      else $error("interrupt dropped without a write");
   a_mask_off: assert property (wr_i && addr_i == 8'h00 && wdata_i == 32'h0 ##1 !wr_i
      |=> irq_lines_o == '0)
      else $error("masked lines still request");
   c_irq: cover property ($rose(irq_o));
   c_evt: cover property (|evt_o);
   c_wake: cover property ($rose(wake_o));
endmodule // eelc_props

bind eelc_top eelc_props #(.NUM_PINS(NUM_PINS)) u_props (.*);

// ---- sim/eelc_src_model.sv ----
// Pin and internal source drivers standing in front of the controller.
`timescale 1ns/10ps
module eelc_src_model #(
   parameter int N = 51
) (
   output logic [N+2:0] src_o
);
   initial src_o = '0;
   // Raises one source for w ns; w may be far below a clock period.
   task automatic pulse(input int k, input int w);
      src_o[k] = 1'b1;
      #(w);
      src_o[k] = 1'b0;
   endtask
endmodule // eelc_src_model

// ---- sim/eelc_tb_top.sv ----
// Self-checking bench for the edge event line controller.
`timescale 1ns/10ps
`include "eelc_map.svh"
module eelc_tb_top;
   import eelc_pkg::*;
   logic        clk_i = 1'b0;
   logic        arst_n_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   eelc_lines_t irq_lines_o;
   eelc_lines_t evt_o;
   logic        irq_o;
   logic        wake_o;
   logic [53:0] src;
   int          err_count = 0;
   int          checks = 0;
   logic [31:0] n;
   // Clock at 40 MHz.
   always #12.5 clk_i = ~clk_i;
   eelc_src_model u_src (.src_o(src));
   eelc_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .pins_i(src[50:0]),
      .supply_threshold_detector_i(src[51]), .calendar_alarm_i(src[52]),
      .spare_src_i(src[53]), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .irq_lines_o(irq_lines_o), .irq_o(irq_o),
      .evt_o(evt_o), .wake_o(wake_o));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   // Waits a bounded time for the interrupt to rise.
   task automatic wait_irq();
      n = 0;
      while (irq_o !== 1'b1 && n < 12) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk({31'h0, irq_o}, 32'h1);
   endtask
   task automatic t_reset();
      for (int a = 0; a <= 16; a += 4) rd(a[7:0], 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h14, 32'h0);
      chk({irq_lines_o, irq_o, wake_o}, 32'h0);
   endtask
   // Sub-period pulse on a selected pin, held pending, then cleared.
   task automatic t_narrow();
      wr(8'h20, 32'h5);
      wr(8'h08, 32'h1);
      wr(8'h00, 32'h1);
      rd(8'h20, 32'h5);
      rd(8'h08, 32'h1);
      rd(8'h00, 32'h1);
      u_src.pulse(5, 5);
      wait_irq();
      chk({irq_lines_o, wake_o}, 32'h3);
      rd(8'h10, 32'h1);
      u_src.pulse(5, 5);
      repeat (8) @(posedge clk_i);
      rd(8'h10, 32'h1);
      wr(8'h10, 32'h1);
      @(posedge clk_i);
      #1 chk({31'h0, irq_o}, 32'h0);
      u_src.pulse(0, 5);
      repeat (8) @(posedge clk_i);
      rd(8'h10, 32'h0);
      // A trigger that lands in the very cycle of a clear must keep the bit set.
      @(posedge clk_i);
      #1 u_src.pulse(5, 5);
      repeat (2) @(posedge clk_i);
      wr(8'h10, 32'h1);
      rd(8'h10, 32'h1);
      wr(8'h10, 32'h1);
      rd(8'h10, 32'h0);
   endtask
   // Falling edge on the supply line; rising edge on the masked alarm line.
   task automatic t_fall_mask();
      wr(8'h0C, 32'h10000);
      wr(8'h08, 32'h20000);
      wr(8'h00, 32'h10000);
      u_src.pulse(52, 60);
      u_src.pulse(51, 60);
      wait_irq();
      rd(8'h10, 32'h10000);
      // Masking the line drops its request while the pending bit stays.
      wr(8'h00, 32'h0);
      @(posedge clk_i);
      #1 chk({irq_lines_o, irq_o}, 32'h0);
      rd(8'h10, 32'h10000);
      wr(8'h10, 32'h10000);
      rd(8'h10, 32'h0);
   endtask
   // Both edges of the alarm line give two events and no pending bit.
   task automatic t_evt();
      wr(8'h0C, 32'h20000);
      wr(8'h04, 32'h20000);
      wr(8'h00, 32'h0);
      rd(8'h04, 32'h20000);
      rd(8'h0C, 32'h20000);
      n = 0;
      fork
         u_src.pulse(52, 200);
         repeat (20) begin
            @(posedge clk_i);
            #1 n += evt_o[17];
         end
      join
      chk(n, 32'h2);
      rd(8'h10, 32'h0);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence.
   initial begin
      // A real falling edge on reset, so the line-clocked toggles are cleared too.
      arst_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_narrow();
      t_fall_mask();
      t_evt();
      tally_and_finish();
   end
   // Watchdog, well beyond the fewer than two hundred cycles the tests need.
   initial begin
      #100us;
      err_count++;
      tally_and_finish();
   end
endmodule // eelc_tb_top
